//--- mfr_sequencer.sv
// Fault reaction sequencer: fault latching, stop sequence, brake and log codes.
//
// Overview of operation
// RL1: Fatal fault disables bridge at once.
// RL2: Internal brake select applies brake on fatal.
// RL3: External brake select never drives the brake.
// RL4: Non-fatal fault starts deceleration at set rate.
// RL5: Brake applies when speed falls below threshold.
// RL6: Bridge disables after brake-to-disable delay.
// RL7: Deceleration deadline forces disable and brake.
// RL8: Brake driven only under internal brake select.
// RL9: Fatal fault latched until device reset.
// RL10: Non-fatal fault clears once condition gone; the latch also needs a clear bit write to the control register.
// RL11: Short circuits logged as group 1 codes.
// RL12: Bus over-voltage logged as group 2.
// RL13: Ambient over-temperature logged as group 4.
// RL14: Bridge over-temperatures logged as group 5.
// RL15: Motor over-temperature logged as group 6.
// RL16: Encoder faults logged as group 7.
// RL17: Resolver loss logged as group 8.
// RL18: Supply faults logged as group 9.
// RL19: Store init and write failures non-fatal.
// RL20: Store address out of range is fatal.
// RL21: Process data object failure is group 11.
// RL22: Fatal during controlled stop aborts the stop.

`timescale 1ns/100ps

module mfr_sequencer
#(
    parameter int TICK_CYCLES = mfr_pkg::MFR_TICK_CYCLES
)
(
    // Clock and reset.
    input  wire logic                                clk,
    input  wire logic                                rstn,
    // Register bus.
    input  wire mfr_pkg::mfr_bus_req_t               busReq,
    output logic [mfr_pkg::MFR_DATA_W-1:0]           busRdata,
    // Fault sources and motion feedback.
    input  wire logic [mfr_pkg::MFR_NUM_FAULTS-1:0]  faultIn,
    input  wire logic [mfr_pkg::MFR_PARAM_W-1:0]     speedAbs,
    input  wire logic                                driveEnableReq,
    // Power stage, brake and motion controller.
    output logic                                     bridgeEnable,
    output logic                                     brakeApply,
    output logic                                     decelActive,
    output logic [mfr_pkg::MFR_PARAM_W-1:0]          decelRate,
    // Fault log.
    output logic                                     logValid,
    output mfr_pkg::mfr_fault_desc_t                 logRec,
    output mfr_pkg::mfr_state_t                      seqState
);
    import mfr_pkg::*;

    localparam int NF = MFR_NUM_FAULTS;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // Software parameters.
    logic                   ctrlBrakeInt_ff;
    logic [MFR_PARAM_W-1:0] decelLimit_ff;
    logic [MFR_PARAM_W-1:0] stopVel_ff;
    logic [MFR_PARAM_W-1:0] brakeDelay_ff;
    logic [MFR_PARAM_W-1:0] rampTimeout_ff;

    // Fault and sequence state.
    logic [NF-1:0]          faultLatch_ff;
    logic [NF-1:0]          logged_ff;
    logic [NF-1:0]          fatalMask;
    mfr_state_t             state_ff;
    mfr_state_t             nxt_state;
    logic [MFR_TICK_W-1:0]  tickCnt_ff;
    logic                   tick;
    logic [MFR_PARAM_W-1:0] elapsed_ff;

    // Outputs.
    logic [MFR_DATA_W-1:0]  busRdata_ff;
    logic                   bridgeEnable_ff;
    logic                   brakeApply_ff;
    logic                   decelActive_ff;
    logic [MFR_PARAM_W-1:0] decelRate_ff;
    logic                   logValid_ff;
    mfr_fault_desc_t        logRec_ff;

    // Bus decode and fault summaries.
    logic                   wrCtrl;
    logic                   clearReq;
    logic                   fatalNow;
    logic                   nonFatalNow;
    logic [NF-1:0]          pending;
    logic                   anyPending;
    logic [4:0]             pendIdx;

    assign wrCtrl   = busReq.wr && (busReq.addr == MFR_REG_CTRL);
    assign clearReq = wrCtrl && busReq.wdata[MFR_CTRL_CLEAR];

    // Per-source latch. A source that is still present wins over a clear in the same cycle.
    for (genvar i = 0; i < NF; i++) begin : g_fault
        assign fatalMask[i] = MFR_FAULT_TAB[i].fatal;

        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                faultLatch_ff[i] <= 1'h0;
            end else if (faultIn[i]) begin
                faultLatch_ff[i] <= 1'h1;
            end else if (clearReq && !MFR_FAULT_TAB[i].fatal) begin
                faultLatch_ff[i] <= 1'h0; // RL10
            end
        end

        // Set once the latched source has been logged.
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                logged_ff[i] <= 1'h0;
            end else if (!faultLatch_ff[i]) begin
                logged_ff[i] <= 1'h0;
            end else if (anyPending && (pendIdx == 5'(i))) begin
                logged_ff[i] <= 1'h1;
            end
        end
    end

    // A fatal source is acted on in the cycle it appears, before it is latched.
    assign fatalNow    = |((faultIn | faultLatch_ff) & fatalMask);  // RL9
    assign nonFatalNow = |((faultIn | faultLatch_ff) & ~fatalMask);

    // Software parameters; only the control register carries a self-clearing bit.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrlBrakeInt_ff <= MFR_DEF_BRAKE_INT;
            decelLimit_ff   <= MFR_DEF_DECEL;
            stopVel_ff      <= MFR_DEF_STOPVEL;
            brakeDelay_ff   <= MFR_DEF_BRKDLY;
            rampTimeout_ff  <= MFR_DEF_RAMPTO;
        end else if (busReq.wr) begin
            case (busReq.addr)
                MFR_REG_CTRL:    ctrlBrakeInt_ff <= busReq.wdata[MFR_CTRL_BRAKE_INT];
                MFR_REG_DECEL:   decelLimit_ff   <= busReq.wdata[MFR_PARAM_W-1:0];
                MFR_REG_STOPVEL: stopVel_ff      <= busReq.wdata[MFR_PARAM_W-1:0];
                MFR_REG_BRKDLY:  brakeDelay_ff   <= busReq.wdata[MFR_PARAM_W-1:0];
                MFR_REG_RAMPTO:  rampTimeout_ff  <= busReq.wdata[MFR_PARAM_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // Millisecond time base for the two stop timeouts.
    assign tick = (tickCnt_ff == MFR_TICK_W'(TICK_CYCLES - 1));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tickCnt_ff <= '0;
        end else if (tick) begin
            tickCnt_ff <= '0;
        end else begin
            tickCnt_ff <= tickCnt_ff + MFR_TICK_W'(1);
        end
    end

    // The prescaler runs free, so a wait of N ticks lasts N-1 to N ticks.
    // Elapsed whole ticks in the current state; saturates rather than wrapping.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            elapsed_ff <= '0;
        end else if (nxt_state != state_ff) begin
            elapsed_ff <= '0;
        end else if (tick && (elapsed_ff != '1)) begin
            elapsed_ff <= elapsed_ff + MFR_PARAM_W'(1);
        end
    end

    // Next-state logic; a fatal source overrides every state.
    always_comb begin
        nxt_state = state_ff;
        if (fatalNow) begin
            nxt_state = MFR_ST_FATAL; // RL1 RL22
        end else begin
            case (state_ff)
                MFR_ST_RUN: begin
                    if (nonFatalNow) begin
                        nxt_state = MFR_ST_DECEL; // RL4
                    end
                end
                MFR_ST_DECEL: begin
                    if (speedAbs < stopVel_ff) begin
                        nxt_state = MFR_ST_BRAKE; // RL5
                    end else if (elapsed_ff >= rampTimeout_ff) begin
                        nxt_state = MFR_ST_STOP; // RL7
                    end
                end
                MFR_ST_BRAKE: begin
                    if (elapsed_ff >= brakeDelay_ff) begin
                        nxt_state = MFR_ST_STOP; // RL6
                    end
                end
                MFR_ST_STOP: begin
                    if (!nonFatalNow) begin
                        nxt_state = MFR_ST_RUN; // RL10
                    end
                end
                MFR_ST_FATAL: begin
                    nxt_state = MFR_ST_FATAL; // RL9
                end
                default: begin
                    nxt_state = MFR_ST_RUN;
                end
            endcase
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= MFR_ST_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // The bridge follows the next state so a fatal source cuts it on the very edge it is seen.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bridgeEnable_ff <= 1'h0;
        end else begin
            bridgeEnable_ff <= driveEnableReq && (nxt_state == MFR_ST_RUN || nxt_state == MFR_ST_DECEL ||
                                                  nxt_state == MFR_ST_BRAKE); // RL1 RL6 RL7
        end
    end

    // With external brake select the output stays released; the user owns the brake then.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            brakeApply_ff <= 1'h0;
        end else begin
            brakeApply_ff <= ctrlBrakeInt_ff && (nxt_state == MFR_ST_FATAL || nxt_state == MFR_ST_BRAKE ||
                                                 nxt_state == MFR_ST_STOP); // RL2 RL3 RL5 RL7 RL8
        end
    end

    // Only the rate is passed on; the motion controller runs the ramp.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            decelActive_ff <= 1'h0;
            decelRate_ff   <= '0;
        end else begin
            decelActive_ff <= (nxt_state == MFR_ST_DECEL); // RL4
            decelRate_ff   <= decelLimit_ff; // RL4
        end
    end

    // One log entry per cycle, lowest source index first; later ones wait their turn.
    assign pending    = faultLatch_ff & ~logged_ff;
    assign anyPending = |pending;

    always_comb begin
        pendIdx = '0;
        for (int k = NF - 1; k >= 0; k--) begin
            if (pending[k]) begin
                pendIdx = 5'(k);
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            logValid_ff <= 1'h0;
            logRec_ff   <= '0;
        end else begin
            logValid_ff <= anyPending;
            if (anyPending) begin
                logRec_ff <= MFR_FAULT_TAB[pendIdx]; // RL11 RL12 RL13 RL14 RL15 RL16 RL17 RL18 RL19 RL20 RL21
            end
        end
    end

    // Register reads answer one cycle later; unmapped offsets read zero.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busRdata_ff <= '0;
        end else if (busReq.rd) begin
            case (busReq.addr)
                MFR_REG_CTRL:    busRdata_ff <= {31'h0, ctrlBrakeInt_ff};
                MFR_REG_DECEL:   busRdata_ff <= {16'h0, decelLimit_ff};
                MFR_REG_STOPVEL: busRdata_ff <= {16'h0, stopVel_ff};
                MFR_REG_BRKDLY:  busRdata_ff <= {16'h0, brakeDelay_ff};
                MFR_REG_RAMPTO:  busRdata_ff <= {16'h0, rampTimeout_ff};
                MFR_REG_STATUS:  busRdata_ff <= {25'h0, bridgeEnable_ff, brakeApply_ff, nonFatalNow,
                                                 fatalNow, state_ff};
                MFR_REG_ACTIVE:  busRdata_ff <= {13'h0, faultLatch_ff};
                MFR_REG_LASTLOG: busRdata_ff <= {18'h0, logRec_ff};
                default:         busRdata_ff <= '0;
            endcase
        end else begin
            busRdata_ff <= '0;
        end
    end

    // Every port is a plain copy of a flip-flop.
    assign busRdata     = busRdata_ff;
    assign bridgeEnable = bridgeEnable_ff;
    assign brakeApply   = brakeApply_ff;
    assign decelActive  = decelActive_ff;
    assign decelRate    = decelRate_ff;
    assign logValid     = logValid_ff;
    assign logRec       = logRec_ff;
    assign seqState     = state_ff;

    // Reaction checks; all are off while in reset.
    a_fatal_cuts_bridge: assert property (|(faultIn & fatalMask) |=> !bridgeEnable && seqState == MFR_ST_FATAL) // RL1
        else $error("fatal fault did not disable bridge");

    a_fatal_brake_on: assert property ((|(faultIn & fatalMask)) && ctrlBrakeInt_ff |=> brakeApply) // RL2
        else $error("fatal fault did not apply brake");

    a_ext_brake_off: assert property (brakeApply |-> $past(ctrlBrakeInt_ff)) // RL3
        else $error("brake driven under external brake select");

    a_decel_start: assert property (seqState == MFR_ST_RUN && !fatalNow && nonFatalNow
                                    |=> decelActive && seqState == MFR_ST_DECEL) // RL4
        else $error("non-fatal fault did not start deceleration");

    a_slow_brake: assert property (seqState == MFR_ST_DECEL && !fatalNow && speedAbs < stopVel_ff
                                   |=> seqState == MFR_ST_BRAKE && (brakeApply == $past(ctrlBrakeInt_ff))) // RL5
        else $error("slow speed did not apply brake");

    a_delay_disable: assert property (seqState == MFR_ST_BRAKE && !fatalNow && elapsed_ff >= brakeDelay_ff
                                      |=> seqState == MFR_ST_STOP && !bridgeEnable) // RL6
        else $error("brake delay did not disable bridge");

    a_delay_hold: assert property (seqState == MFR_ST_BRAKE && !fatalNow && elapsed_ff < brakeDelay_ff
                                   |=> seqState == MFR_ST_BRAKE) // RL6
        else $error("bridge disabled before brake delay");

    a_ramp_deadline: assert property (seqState == MFR_ST_DECEL && !fatalNow && speedAbs >= stopVel_ff &&
                                      elapsed_ff >= rampTimeout_ff |=> seqState == MFR_ST_STOP && !bridgeEnable) // RL7
        else $error("deceleration deadline not enforced");

    a_fatal_sticky: assert property (seqState == MFR_ST_FATAL |=> seqState == MFR_ST_FATAL [*8]) // RL9
        else $error("fatal state left without reset");

    a_nonfatal_clear: assert property (clearReq && !fatalNow && faultIn == '0 |=> faultLatch_ff == '0) // RL10
        else $error("non-fatal faults not cleared");

    a_oob_fatal_code: assert property (logValid && logRec.code == 8'h7B |-> logRec.fatal) // RL20
        else $error("store address fault logged as non-fatal");

    a_log_code_map: assert property (anyPending |=> logValid && logRec == MFR_FAULT_TAB[$past(pendIdx)]) // RL11
        else $error("logged status code does not match source");

    a_stop_abort: assert property (seqState inside {MFR_ST_DECEL, MFR_ST_BRAKE, MFR_ST_STOP} && fatalNow
                                   |=> seqState == MFR_ST_FATAL && !decelActive) // RL22
        else $error("fatal fault did not abort controlled stop");

    a_clear_keeps_fatal: assert property (clearReq && fatalNow |=> fatalNow) // RL9
        else $error("clear write removed a fatal fault");

    a_set_beats_clear: assert property (clearReq // RL10
        |=> (faultLatch_ff & $past(faultIn)) == $past(faultIn))
        else $error("clear dropped a fault still present");

    a_run_brake_free: assert property (seqState == MFR_ST_RUN |-> !brakeApply) // RL10
        else $error("brake applied while running");

    a_bridge_needs_req: assert property (!driveEnableReq |=> !bridgeEnable)
        else $error("bridge enabled without drive request");

endmodule : mfr_sequencer

//--- mfr_pkg.sv
// Shared constants, register map and fault table for the fault reaction sequencer.
package mfr_pkg;

    // Clock and time base.
    localparam int MFR_CLK_PERIOD_NS = 25;
    localparam int MFR_TICK_NS       = 1000000;
    localparam int MFR_TICK_CYCLES   = (MFR_TICK_NS + MFR_CLK_PERIOD_NS - 1) / MFR_CLK_PERIOD_NS;

    // Widths.
    localparam int MFR_ADDR_W  = 8;
    localparam int MFR_DATA_W  = 32;
    localparam int MFR_PARAM_W = 16;
    localparam int MFR_TICK_W  = 16;

    // Register byte offsets.
    localparam logic [7:0] MFR_REG_CTRL    = 8'h00;
    localparam logic [7:0] MFR_REG_DECEL   = 8'h04;
    localparam logic [7:0] MFR_REG_STOPVEL = 8'h08;
    localparam logic [7:0] MFR_REG_BRKDLY  = 8'h0C;
    localparam logic [7:0] MFR_REG_RAMPTO  = 8'h10;
    localparam logic [7:0] MFR_REG_STATUS  = 8'h14;
    localparam logic [7:0] MFR_REG_ACTIVE  = 8'h18;
    localparam logic [7:0] MFR_REG_LASTLOG = 8'h1C;

    // Control register fields.
    localparam int MFR_CTRL_BRAKE_INT = 0;
    localparam int MFR_CTRL_CLEAR     = 1;

    // Reset values of the software parameters.
    localparam logic       MFR_DEF_BRAKE_INT = 1'h1;
    localparam logic [15:0] MFR_DEF_DECEL    = 16'h0100;
    localparam logic [15:0] MFR_DEF_STOPVEL  = 16'h0010;
    localparam logic [15:0] MFR_DEF_BRKDLY   = 16'h0064;
    localparam logic [15:0] MFR_DEF_RAMPTO   = 16'h07D0;

    // Sequencer states.
    typedef enum logic [2:0] {
        MFR_ST_RUN   = 3'b000,
        MFR_ST_DECEL = 3'b001,
        MFR_ST_BRAKE = 3'b010,
        MFR_ST_STOP  = 3'b011,
        MFR_ST_FATAL = 3'b100
    } mfr_state_t;

    // One fault source: severity, group and logged status code.
    typedef struct packed {
        logic       fatal;
        logic [4:0] group;
        logic [7:0] code;
    } mfr_fault_desc_t;

    // One register bus request.
    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic [MFR_ADDR_W-1:0] addr;
        logic [MFR_DATA_W-1:0] wdata;
    } mfr_bus_req_t;

    localparam int MFR_NUM_FAULTS = 19;

    // Fault input index order matches this table.
    localparam mfr_fault_desc_t MFR_FAULT_TAB [MFR_NUM_FAULTS] = '{
        '{1'h0, 5'h01, 8'h3D},  // RL11
        '{1'h0, 5'h01, 8'h49},  // RL11
        '{1'h0, 5'h01, 8'h4D},  // RL11
        '{1'h0, 5'h02, 8'h3A},  // RL12
        '{1'h0, 5'h04, 8'h1A},  // RL13
        '{1'h0, 5'h05, 8'h4B},  // RL14
        '{1'h0, 5'h05, 8'h5E},  // RL14
        '{1'h0, 5'h06, 8'h4C},  // RL15
        '{1'h0, 5'h07, 8'h48},  // RL16
        '{1'h0, 5'h07, 8'h51},  // RL16
        '{1'h0, 5'h07, 8'h52},  // RL16
        '{1'h0, 5'h08, 8'h4A},  // RL17
        '{1'h0, 5'h09, 8'h40},  // RL18
        '{1'h0, 5'h09, 8'h42},  // RL18
        '{1'h0, 5'h09, 8'h43},  // RL18
        '{1'h0, 5'h0A, 8'hA8},  // RL19
        '{1'h0, 5'h0A, 8'h0C},  // RL19
        '{1'h1, 5'h0A, 8'h7B},  // RL20
        '{1'h0, 5'h0B, 8'h05}   // RL21
    };

endpackage : mfr_pkg

//--- mfr_plant_model.sv
// Behavioural power stage, holding brake and motion controller seen by the sequencer.
`timescale 1ns/100ps

module mfr_plant_model
(
    // Clock and reset.
    input  wire logic                            clk,
    input  wire logic                            rstn,
    // Sequencer outputs.
    input  wire logic                            bridgeEnable,
    input  wire logic                            brakeApply,
    input  wire logic                            decelActive,
    input  wire logic [mfr_pkg::MFR_PARAM_W-1:0] decelRate,
    // Bench controls.
    input  wire logic                            brakeInternal,
    input  wire logic                            speedLoad,
    input  wire logic [mfr_pkg::MFR_PARAM_W-1:0] speedVal,
    input  wire logic                            stall,
    // Plant responses.
    output logic      [mfr_pkg::MFR_PARAM_W-1:0] speedAbs,
    output logic                                 brakeHeld
);
    import mfr_pkg::*;

    logic [MFR_PARAM_W-1:0] speed_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            speed_ff <= '0;
        end else if (speedLoad) begin
            speed_ff <= speedVal;
        end else if (decelActive && !stall) begin
            // A stalled load ignores the ramp, so the speed stays at or above the stop velocity until the deadline path is taken.
            speed_ff <= (speed_ff > decelRate) ? speed_ff - decelRate : '0;
        end
    end

    assign speedAbs = speed_ff;

    // Under external control the outside party clamps the brake once the bridge is off.
    assign brakeHeld = brakeInternal ? brakeApply : !bridgeEnable;

endmodule : mfr_plant_model

//--- tb.sv
// Self-checking testbench for the fault reaction sequencer.
`timescale 1ns/100ps

module tb;
    import mfr_pkg::*;

    localparam int TICK = 8;

    logic                  clk;
    logic                  rstn;
    mfr_bus_req_t          busReq;
    logic [MFR_DATA_W-1:0] busRdata;
    logic [18:0]           faultIn;
    logic [15:0]           speedAbs;
    logic [15:0]           speedVal;
    logic [15:0]           decelRate;
    logic                  driveEnableReq;
    logic                  bridgeEnable;
    logic                  brakeApply;
    logic                  decelActive;
    logic                  logValid;
    mfr_fault_desc_t       logRec;
    mfr_state_t            seqState;
    logic                  brakeInternal;
    logic                  speedLoad;
    logic                  stall;
    logic                  brakeHeld;
    logic [31:0]           rdv;
    int                    errCount;
    int                    checkCount;
    int                    n;
    // Expected group and status code of each fault input.
    int grp [19] = '{1, 1, 1, 2, 4, 5, 5, 6, 7, 7, 7, 8, 9, 9, 9, 10, 10, 10, 11};
    int code [19] = '{61, 73, 77, 58, 26, 75, 94, 76, 72, 81, 82, 74, 64, 66, 67, 168, 12, 123, 5};

    mfr_sequencer #(.TICK_CYCLES(TICK)) dut_u (
        .clk(clk), .rstn(rstn), .busReq(busReq), .busRdata(busRdata), .faultIn(faultIn),
        .speedAbs(speedAbs), .driveEnableReq(driveEnableReq), .bridgeEnable(bridgeEnable),
        .brakeApply(brakeApply), .decelActive(decelActive), .decelRate(decelRate),
        .logValid(logValid), .logRec(logRec), .seqState(seqState));

    mfr_plant_model plant_u (
        .clk(clk), .rstn(rstn), .bridgeEnable(bridgeEnable), .brakeApply(brakeApply),
        .decelActive(decelActive), .decelRate(decelRate), .brakeInternal(brakeInternal),
        .speedLoad(speedLoad), .speedVal(speedVal), .stall(stall), .speedAbs(speedAbs),
        .brakeHeld(brakeHeld));

    always #12.5 clk = ~clk;

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", checkCount, errCount);
        if (errCount == 0 && checkCount > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            errCount++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        busReq <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
        @(posedge clk);
        busReq <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        busReq <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 32'h0};
        @(posedge clk);
        busReq <= '0;
        @(negedge clk);
        d = busRdata;
    endtask : rd

    function automatic logic cond(input int k);
        case (k)
            0: return brakeApply;
            1: return !bridgeEnable;
            default: return seqState === MFR_ST_RUN;
        endcase
    endfunction : cond

    // Bounded wait; running out of cycles is a mismatch and ends the run.
    task automatic waitc(input int k, input int lim, output int cnt);
        cnt = 0;
        @(negedge clk);
        while (cond(k) !== 1'h1) begin
            @(negedge clk);
            cnt++;
            if (cnt > lim) begin
                chk("wait bound", 32'h0, 32'h1);
                wrap_up();
            end
        end
    endtask : waitc

    task automatic raise(input int idx);
        @(posedge clk);
        faultIn[idx] <= 1'h1;
        @(posedge clk);
        @(negedge clk);
    endtask : raise

    task automatic clear_all(input logic intSel);
        @(posedge clk);
        faultIn <= '0;
        wr(MFR_REG_CTRL, {30'h0, 1'h1, intSel});
        waitc(2, 4, n);
    endtask : clear_all

    task automatic load_speed(input logic [15:0] v);
        @(posedge clk);
        speedLoad <= 1'h1;
        speedVal  <= v;
        @(posedge clk);
        speedLoad <= 1'h0;
    endtask : load_speed

    task automatic do_reset();
        @(posedge clk);
        rstn <= 1'h0;
        faultIn <= '0;
        repeat (3) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        @(negedge clk);
        chk("stateAfterReset", MFR_ST_RUN, seqState);
        chk("bridgeAfterReset", 32'h1, bridgeEnable);
    endtask : do_reset

    task automatic t_regs();
        logic [7:0]  a [6] = '{MFR_REG_CTRL, MFR_REG_DECEL, MFR_REG_STOPVEL, MFR_REG_BRKDLY, MFR_REG_RAMPTO, 8'h20};
        logic [31:0] e [6] = '{32'h1, 32'h100, 32'h10, 32'h64, 32'h7D0, 32'h0};
        for (int i = 0; i < 6; i++) begin
            rd(a[i], rdv);
            chk("regReset", e[i], rdv);
        end
        chk("brakeIdle", 32'h0, brakeApply);
        @(posedge clk);
        driveEnableReq <= 1'h0;
        @(posedge clk);
        driveEnableReq <= 1'h1;
        @(negedge clk);
        chk("bridgeNoRequest", 32'h0, bridgeEnable);
    endtask : t_regs

    // Each non-fatal source: log entry, stop and forced disable at a zero deadline.
    task automatic t_codes();
        wr(MFR_REG_RAMPTO, 32'h0);
        for (int i = 0; i < 19; i++) begin
            if (i == 17) continue;
            raise(i);
            chk("decelState", MFR_ST_DECEL, seqState);
            chk("decelActive", 32'h1, decelActive);
            chk("decelRate", 32'h100, decelRate);
            @(negedge clk);
            chk("logValid", 32'h1, logValid);
            chk("logRec", {18'h0, 1'h0, 5'(grp[i]), 8'(code[i])}, logRec);
            waitc(1, 2 * TICK, n);
            chk("brakeAtDeadline", 32'h1, brakeApply);
            clear_all(1'h1);
            chk("brakeReleased", 32'h0, brakeApply);
        end
    endtask : t_codes

    task automatic t_stop();
        wr(MFR_REG_RAMPTO, 32'h7D0);
        wr(MFR_REG_BRKDLY, 32'h3);
        load_speed(16'h0400);
        @(posedge clk);
        stall <= 1'h0;
        raise(7);
        waitc(0, 20, n);
        chk("bridgeAtBrake", 32'h1, bridgeEnable);
        chk("slowAtBrake", 32'h1, speedAbs < 16'h0010);
        chk("brakeState", MFR_ST_BRAKE, seqState);
        waitc(1, 4 * TICK + 4, n);
        chk("delayNotShort", 32'h1, n >= 2 * TICK);
        wr(MFR_REG_CTRL, 32'h3);
        rd(MFR_REG_ACTIVE, rdv);
        chk("clearWhileHigh", 32'h1, rdv[7]);
        clear_all(1'h1);
        rd(MFR_REG_ACTIVE, rdv);
        chk("clearedActive", 32'h0, rdv);
        @(posedge clk);
        stall <= 1'h1;
    endtask : t_stop

    task automatic t_deadline();
        @(posedge clk);
        brakeInternal <= 1'h0;
        wr(MFR_REG_CTRL, 32'h0);
        wr(MFR_REG_RAMPTO, 32'h2);
        load_speed(16'h0400);
        raise(0);
        waitc(1, 3 * TICK + 4, n);
        chk("deadlineNotEarly", 32'h1, n >= TICK);
        chk("noBrakeExternal", 32'h0, brakeApply);
        chk("outsideBrake", 32'h1, brakeHeld);
        clear_all(1'h0);
        brakeInternal <= 1'h1;
        wr(MFR_REG_CTRL, 32'h1);
        wr(MFR_REG_RAMPTO, 32'h7D0);
    endtask : t_deadline

    task automatic t_fatal();
        raise(4);
        chk("decelBeforeFatal", MFR_ST_DECEL, seqState);
        raise(17);
        chk("fatalBridge", 32'h0, bridgeEnable);
        chk("fatalBrake", 32'h1, brakeApply);
        chk("fatalState", MFR_ST_FATAL, seqState);
        @(negedge clk);
        chk("fatalLog", {18'h0, 1'h1, 5'h0A, 8'(code[17])}, logRec);
        @(posedge clk);
        faultIn <= '0;
        wr(MFR_REG_CTRL, 32'h3);
        repeat (4) @(negedge clk);
        chk("fatalHeld", MFR_ST_FATAL, seqState);
        rd(MFR_REG_ACTIVE, rdv);
        chk("fatalLatched", 32'h1, rdv[17]);
        do_reset();
        @(posedge clk);
        brakeInternal <= 1'h0;
        wr(MFR_REG_CTRL, 32'h0);
        raise(17);
        chk("extFatalBridge", 32'h0, bridgeEnable);
        chk("extFatalBrake", 32'h0, brakeApply);
        chk("extOutsideBrake", 32'h1, brakeHeld);
        do_reset();
    endtask : t_fatal

    initial begin
        clk            = 1'h0;
        rstn           = 1'h0;
        busReq         = '0;
        faultIn        = '0;
        speedVal       = 16'h0;
        speedLoad      = 1'h0;
        stall          = 1'h1;
        driveEnableReq = 1'h1;
        brakeInternal  = 1'h1;
        errCount       = 0;
        checkCount     = 0;
        repeat (3) @(posedge clk);
        rstn <= 1'h1;
        load_speed(16'h0400);
        t_regs();
        t_codes();
        t_stop();
        t_deadline();
        t_fatal();
        wrap_up();
    end

endmodule : tb
